// ### inc/pwk_pkg.sv
/*
 * Package for the per-port wake event and interrupt summary block.
 * Holds register map, field positions, reset values and carrier structs.
 */
`default_nettype none
package pwk_pkg;
    // Printed offsets are not word multiples: kept as indices, byte address = 4 * index
    localparam int unsigned NUM_PORTS        = 3;
    localparam logic [7:0]  IDX_SR2_TYPE     = 8'h0a;
    localparam logic [7:0]  IDX_WAKE_EVENT   = 8'h13;
    localparam logic [7:0]  IDX_WAKE_ENABLE  = 8'h17;
    localparam logic [7:0]  IDX_INT_SUMMARY  = 8'h1b;
    localparam logic [7:0]  IDX_INT_MASK     = 8'h1f;
    localparam logic [7:0]  IDX_MAC_ADDR_LO  = 8'h30;
    localparam logic [7:0]  IDX_MAC_ADDR_HI  = 8'h31;
    localparam logic [7:0]  IDX_IRQ_STATUS   = 8'h40;
    localparam logic [7:0]  IDX_IRQ_ENABLE   = 8'h41;
    localparam logic [7:0]  IDX_IRQ_CLEAR    = 8'h42;
    // Port field: byte address bits [13:12] hold port number 1..3
    localparam int unsigned PORT_LSB         = 12;
    localparam int unsigned IDX_LSB          = 2;
    localparam logic [15:0] SR2_TYPE_RESET   = 16'h88b5;
    localparam int unsigned BIT_WAKE_FRAME   = 2;
    localparam int unsigned BIT_LINK_UP      = 1;
    localparam int unsigned BIT_ENERGY       = 0;
    localparam int unsigned BIT_TS_INT       = 2;
    localparam int unsigned BIT_PHY_INT      = 1;
    localparam int unsigned BIT_FILTER_INT   = 0;
    localparam logic [2:0]  PHY_PORT_MASK    = 3'h3;
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;

    typedef struct packed {
        logic       wake_frame;
        logic [47:0] dest_addr;
        logic       link_up;
        logic       energy;
        logic       ts_pending;
        logic       phy_pending;
        logic       filter_irq;
    } pwk_port_ev_s;
endpackage
`default_nettype wire

// ### design/pwk_top.sv
/*
 * Wake event flags, wake pin and interrupt summary for switch ports 1..3,
 * with an AHB-Lite register slave. Assumes event inputs are pulses from
 * logic on clock_i, except the level sources which are synchronised here.
 */
// Notes on behaviour
// - Wake frame counts only if destination matches switch address
// - Wake frame sets event bit 2, software clears
// - PHY link-up sets event bit 1
// - PHY cable energy sets event bit 0
// - Enable bit 2 routes wake frame to pin
// - Enable bit 1 routes link-up to pin
// - Enable bit 0 routes energy to pin
// - Disabled sources never assert pin; enables reset zero
// - PHY port summary bit 1 mirrors PHY pending
// - Filter counter interrupt sets summary bit 0
// - Toggling filter mask bit clears filter status
// - Only unmasked summary sources reach interrupt; reset zero
// - Mask bit zero enables, one disables
`timescale 1ns/1ps
`default_nettype none
module pwk_top (
    input  wire logic                  clock_i,
    input  wire logic                  srst_i,
    input  wire logic                  hsel_i,
    input  wire logic [15:0]           haddr_i,
    input  wire logic [1:0]            htrans_i,
    input  wire logic                  hwrite_i,
    input  wire logic [2:0]            hsize_i,
    input  wire logic [31:0]           hwdata_i,
    input  wire logic                  hready_i,
    input  wire pwk_pkg::pwk_port_ev_s port_ev_i [3],
    output logic      [31:0]           hrdata_o,
    output logic                       hreadyout_o,
    output logic                       hresp_o,
    output logic                       power_mgmt_event_pin_o,
    output logic                       port_irq_o,
    output logic                       irq_o
);
    logic [47:0] mac_addr_q;
    logic [15:0] sr2_type_q [3];
    logic [2:0]  wake_flags_q [3];
    logic [2:0]  wake_en_q [3];
    logic [2:0]  int_mask_q [3];
    logic        filter_st_q [3];
    logic [2:0]  irq_st_q;
    logic [2:0]  irq_en_q;
    logic [2:0]  ts_s1_q;
    logic [2:0]  ts_s2_q;
    logic [2:0]  phy_s1_q;
    logic [2:0]  phy_s2_q;
    logic        wr_pend_q;
    logic [15:0] wr_addr_q;
    logic [2:0]  wake_frame_ok;
    logic [2:0]  pin_d;
    logic [2:0]  sum_int;
    logic [2:0]  port_wr;
    logic [7:0]  wr_idx;
    logic [1:0]  wr_port;
    logic        rd_take;

    function automatic logic [2:0] summary(input logic ts, input logic phy, input logic access_filter, input int p);
        logic [2:0] s;
        s = 3'h0;
        s[pwk_pkg::BIT_TS_INT] = ts & pwk_pkg::PHY_PORT_MASK[p];
        s[pwk_pkg::BIT_PHY_INT] = phy & pwk_pkg::PHY_PORT_MASK[p];
        s[pwk_pkg::BIT_FILTER_INT] = access_filter;
        return s;
    endfunction

    assign wr_idx  = wr_addr_q[pwk_pkg::IDX_LSB +: 8];
    assign wr_port = wr_addr_q[pwk_pkg::PORT_LSB +: 2];
    assign rd_take = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;

    // Level sources cross from PHY and timestamp logic domains
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            ts_s1_q  <= 3'h0;
            ts_s2_q  <= 3'h0;
            phy_s1_q <= 3'h0;
            phy_s2_q <= 3'h0;
        end
        else
        begin
            for (int p = 0; p < 3; p++)
            begin
                ts_s1_q[p]  <= port_ev_i[p].ts_pending;
                phy_s1_q[p] <= port_ev_i[p].phy_pending;
            end
            ts_s2_q  <= ts_s1_q;
            phy_s2_q <= phy_s1_q;
        end
    end

    // Write address phase captured, data applied next cycle; zero wait states
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 16'h0000;
        end
        else
        begin
            wr_pend_q <= hsel_i & hready_i & htrans_i[1] & hwrite_i;
            wr_addr_q <= haddr_i;
        end
    end

    always_comb
    begin
        for (int p = 0; p < 3; p++)
        begin
            port_wr[p] = wr_pend_q & (wr_port == 2'(p + 1));
            wake_frame_ok[p] = port_ev_i[p].wake_frame & (port_ev_i[p].dest_addr == mac_addr_q);
            // OR of enabled and set flags
            pin_d[p] = |(wake_flags_q[p] & wake_en_q[p]);
            sum_int[p] = |(summary(ts_s2_q[p], phy_s2_q[p], filter_st_q[p], p) & ~int_mask_q[p]);
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            mac_addr_q <= 48'h0;
            for (int p = 0; p < 3; p++)
            begin
                sr2_type_q[p] <= pwk_pkg::SR2_TYPE_RESET;
                wake_en_q[p]  <= 3'h0;
                int_mask_q[p] <= 3'h0;
            end
            irq_en_q <= 3'h0;
        end
        else if (wr_pend_q)
        begin
            if (wr_idx == pwk_pkg::IDX_MAC_ADDR_LO)
                mac_addr_q[31:0] <= hwdata_i;
            if (wr_idx == pwk_pkg::IDX_MAC_ADDR_HI)
                mac_addr_q[47:32] <= hwdata_i[15:0];
            if (wr_idx == pwk_pkg::IDX_IRQ_ENABLE)
                irq_en_q <= hwdata_i[2:0];
            for (int p = 0; p < 3; p++)
            begin
                if (port_wr[p] && wr_idx == pwk_pkg::IDX_SR2_TYPE)
                    sr2_type_q[p] <= hwdata_i[15:0];
                // link-up and energy enables only on PHY ports
                if (port_wr[p] && wr_idx == pwk_pkg::IDX_WAKE_ENABLE)
                    wake_en_q[p] <= hwdata_i[2:0] & {1'b1, {2{pwk_pkg::PHY_PORT_MASK[p]}}};
                if (port_wr[p] && wr_idx == pwk_pkg::IDX_INT_MASK)
                    int_mask_q[p] <= hwdata_i[2:0];
            end
        end
    end

    // Flags: set wins over a same-cycle clear
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            for (int p = 0; p < 3; p++)
            begin
                wake_flags_q[p] <= 3'h0;
                filter_st_q[p]  <= 1'b0;
            end
        end
        else
        begin
            for (int p = 0; p < 3; p++)
            begin
                logic [2:0] set_v;
                logic [2:0] clr_v;
                set_v = 3'h0;
                set_v[pwk_pkg::BIT_WAKE_FRAME] = wake_frame_ok[p];
                set_v[pwk_pkg::BIT_LINK_UP] = port_ev_i[p].link_up & pwk_pkg::PHY_PORT_MASK[p];
                // cable energy on PHY ports only
                set_v[pwk_pkg::BIT_ENERGY] = port_ev_i[p].energy & pwk_pkg::PHY_PORT_MASK[p];
                clr_v = (port_wr[p] && wr_idx == pwk_pkg::IDX_WAKE_EVENT) ? hwdata_i[2:0] : 3'h0;
                wake_flags_q[p] <= (wake_flags_q[p] & ~clr_v) | set_v;
                if (port_ev_i[p].filter_irq)
                    filter_st_q[p] <= 1'b1;
                else if (port_wr[p] && wr_idx == pwk_pkg::IDX_INT_MASK
                         && hwdata_i[pwk_pkg::BIT_FILTER_INT] != int_mask_q[p][pwk_pkg::BIT_FILTER_INT])
                    filter_st_q[p] <= 1'b0;
            end
        end
    end

    // Sticky per-port summary rise status, write-one clear
    logic [2:0] sum_prev_q;
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            irq_st_q   <= 3'h0;
            sum_prev_q <= 3'h0;
        end
        else
        begin
            sum_prev_q <= sum_int;
            irq_st_q   <= (irq_st_q & ~((wr_pend_q && wr_idx == pwk_pkg::IDX_IRQ_CLEAR) ? hwdata_i[2:0] : 3'h0))
                          | (sum_int & ~sum_prev_q);
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            power_mgmt_event_pin_o <= 1'b0;
            port_irq_o             <= 1'b0;
            irq_o                  <= 1'b0;
        end
        else
        begin
            // any enabled event flag (wake frame, link-up or energy) drives pin
            power_mgmt_event_pin_o <= |pin_d;
            port_irq_o             <= |sum_int;
            irq_o                  <= |(irq_st_q & irq_en_q);
        end
    end

    // Read data registered; answer in the data phase with no wait
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
            hrdata_o <= 32'h0;
        else if (rd_take)
        begin
            logic [7:0] idx;
            logic [1:0] pn;
            idx = haddr_i[pwk_pkg::IDX_LSB +: 8];
            pn  = haddr_i[pwk_pkg::PORT_LSB +: 2];
            hrdata_o <= 32'h0;
            if (idx == pwk_pkg::IDX_MAC_ADDR_LO)
                hrdata_o <= mac_addr_q[31:0];
            else if (idx == pwk_pkg::IDX_MAC_ADDR_HI)
                hrdata_o <= {16'h0, mac_addr_q[47:32]};
            else if (idx == pwk_pkg::IDX_IRQ_STATUS)
                hrdata_o <= {29'h0, irq_st_q};
            else if (idx == pwk_pkg::IDX_IRQ_ENABLE)
                hrdata_o <= {29'h0, irq_en_q};
            else if (pn != 2'h0)
            begin
                case (idx)
                    pwk_pkg::IDX_SR2_TYPE:    hrdata_o <= {16'h0, sr2_type_q[pn - 2'h1]};
                    pwk_pkg::IDX_WAKE_EVENT:  hrdata_o <= {29'h0, wake_flags_q[pn - 2'h1]};
                    pwk_pkg::IDX_WAKE_ENABLE: hrdata_o <= {29'h0, wake_en_q[pn - 2'h1]};
                    pwk_pkg::IDX_INT_SUMMARY: hrdata_o <= {29'h0, summary(ts_s2_q[pn - 2'h1], phy_s2_q[pn - 2'h1],
                                                           filter_st_q[pn - 2'h1], int'(pn - 2'h1))};
                    pwk_pkg::IDX_INT_MASK:    hrdata_o <= {29'h0, int_mask_q[pn - 2'h1]};
                    default:                  hrdata_o <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            hreadyout_o <= 1'b0;
            hresp_o     <= 1'b0;
        end
        else
        begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    // a flag with its enable clear cannot raise the pin
    pin_gate_a: assert property (@(posedge clock_i) disable iff (srst_i)
        !(|pin_d) |=> !power_mgmt_event_pin_o) else $error("wake pin without enabled flag");
    addr_match_a: assert property (@(posedge clock_i) disable iff (srst_i)
        port_ev_i[2].wake_frame && port_ev_i[2].dest_addr != mac_addr_q && !wake_flags_q[2][2]
        |=> !wake_flags_q[2][2]) else $error("wake frame flag set on foreign address");
    // matched frame sets flag next cycle
    wake_set_a: assert property (@(posedge clock_i) disable iff (srst_i)
        wake_frame_ok[0] |=> wake_flags_q[0][2]) else $error("wake flag not set");
    // MAC port link-up flag stays clear
    mac_link_a: assert property (@(posedge clock_i) disable iff (srst_i)
        !wake_flags_q[2][1]) else $error("link flag on MAC port");
    energy_set_a: assert property (@(posedge clock_i) disable iff (srst_i)
        port_ev_i[1].energy |=> wake_flags_q[1][0]) else $error("energy flag not set");
    // pin follows enabled flags one cycle later
    pin_follow_a: assert property (@(posedge clock_i) disable iff (srst_i)
        (|pin_d) |=> power_mgmt_event_pin_o) else $error("wake pin missed enabled flag");
    // toggle without event clears filter status
    filter_clr_a: assert property (@(posedge clock_i) disable iff (srst_i)
        port_wr[0] && wr_idx == pwk_pkg::IDX_INT_MASK && hwdata_i[0] != int_mask_q[0][0]
        && !port_ev_i[0].filter_irq |=> !filter_st_q[0]) else $error("filter status not cleared");
    // ones in mask keep pending sources out
    mask_gate_a: assert property (@(posedge clock_i) disable iff (srst_i)
        int_mask_q[0] == 3'h6 && !filter_st_q[0] |-> !sum_int[0])
        else $error("masked source raised interrupt");
endmodule
`default_nettype wire

// ### verification/pwk_pm_model.sv
/*
 * System power manager model watching the wake pin.
 * Assumes a level request pin synchronous to clock_i.
 */
`timescale 1ns/1ps
`default_nettype none
module pwk_pm_model #(
    parameter int DELAY = 1
) (
    input  wire logic       clock_i,
    input  wire logic       srst_i,
    input  wire logic       wake_i,
    output logic [7:0]      rises_o,
    output logic            awake_o
);
    logic       prev_q;
    int         cnt_q;
    // Every rise is one wake request, so a glitching pin shows as extra wakes
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            prev_q  <= 1'b0;
            rises_o <= 8'h00;
        end
        else
        begin
            prev_q <= wake_i;
            if (wake_i && !prev_q)
                rises_o <= rises_o + 8'h01;
        end
    end
    // Slow wake: needs DELAY cycles of steady request
    always_ff @(posedge clock_i)
    begin
        if (srst_i || !wake_i)
            cnt_q <= 0;
        else if (cnt_q < DELAY)
            cnt_q <= cnt_q + 1;
    end
    assign awake_o = (cnt_q >= DELAY);
endmodule
`default_nettype wire

// ### verification/test_port_wake_event_interrupt_status.sv
/*
 * Self-checking bench for the port wake and interrupt summary block.
 * Assumes pwk_pkg, pwk_top and pwk_pm_model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module test_port_wake_event_interrupt_status;
    logic                  clock_i;
    logic                  srst_i;
    logic                  hsel;
    logic [15:0]           haddr;
    logic [1:0]            htrans;
    logic                  hwrite;
    logic [31:0]           hwdata;
    logic [31:0]           hrdata;
    logic                  hrdy;
    logic                  pin;
    logic                  pirq;
    logic                  irq;
    logic [7:0]            rises;
    pwk_pkg::pwk_port_ev_s ev [3];
    logic [31:0]           exp_q [$];
    logic                  rd_pend = 1'b0;
    logic                  hresp;
    logic                  awake;
    logic [47:0]           mac;
    logic [15:0]           t;
    integer                seed;
    int                    mismatches;
    int                    num_checks;

    pwk_top DUT (.clock_i(clock_i), .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .port_ev_i(ev),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .power_mgmt_event_pin_o(pin),
        .port_irq_o(pirq), .irq_o(irq));
    pwk_pm_model #(.DELAY(3)) PM (.clock_i(clock_i), .srst_i(srst_i), .wake_i(pin), .rises_o(rises),
        .awake_o(awake));

    initial
    begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (mismatches == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic bus(input logic w, input int p, input logic [7:0] i, input logic [31:0] d);
        @(posedge clock_i);
        hsel   <= 1'b1;
        haddr  <= (16'(p) << pwk_pkg::PORT_LSB) | (16'(i) << pwk_pkg::IDX_LSB);
        htrans <= pwk_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clock_i); while (hrdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock_i); while (hrdy !== 1'b1);
    endtask

    task automatic rd(input int p, input logic [7:0] i, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, p, i, 32'h0);
    endtask

    // Event codes: 0 wake frame, 1 link-up, 2 energy, 3 filter
    task automatic pulse(input int p, input int k, input logic [47:0] da);
        @(posedge clock_i);
        ev[p-1].dest_addr <= da;
        {ev[p-1].wake_frame, ev[p-1].link_up, ev[p-1].energy, ev[p-1].filter_irq} <= 4'h8 >> k;
        @(posedge clock_i);
        {ev[p-1].wake_frame, ev[p-1].link_up, ev[p-1].energy, ev[p-1].filter_irq} <= 4'h0;
    endtask

    // Pin, port interrupt, device interrupt after the registered path settles
    task automatic outs(input logic [2:0] e);
        repeat (5) @(posedge clock_i);
        #1 check({29'h0, pin, pirq, irq}, {29'h0, e});
        check({31'h0, awake}, {31'h0, e[2]});
    endtask

    // Read results are compared in order as each data phase completes
    always @(posedge clock_i)
    begin
        if (rd_pend && hrdy === 1'b1)
        begin
            check(hrdata, exp_q.pop_front());
            check({31'h0, hresp}, 32'h0);
            rd_pend = 1'b0;
        end
        if (hsel && htrans[1] && !hwrite && hrdy === 1'b1)
            rd_pend = 1'b1;
    end

    initial
    begin
        repeat (20000) @(posedge clock_i);
        mismatches++;
        stop_test();
    end

    initial
    begin
        seed = 68263;
        mismatches = 0;
        num_checks = 0;
        hsel = 1'b0;
        haddr = 16'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        for (int p = 0; p < 3; p++)
            ev[p] = '0;
        srst_i = 1'b1;
        repeat (10) @(posedge clock_i);
        srst_i <= 1'b0;
        @(posedge clock_i);
        for (int p = 1; p <= 3; p++)
        begin
            rd(p, pwk_pkg::IDX_SR2_TYPE, {16'h0, pwk_pkg::SR2_TYPE_RESET});
            rd(p, pwk_pkg::IDX_WAKE_EVENT, 32'h0);
            rd(p, pwk_pkg::IDX_WAKE_ENABLE, 32'h0);
            rd(p, pwk_pkg::IDX_INT_SUMMARY, 32'h0);
            rd(p, pwk_pkg::IDX_INT_MASK, 32'h0);
            rd(p, 8'h05, 32'h0);
            t = 16'($random(seed));
            bus(1'b1, p, pwk_pkg::IDX_SR2_TYPE, {16'h0, t});
            rd(p, pwk_pkg::IDX_SR2_TYPE, {16'h0, t});
        end
        mac[47:32] = 16'($random(seed));
        mac[31:0] = $random(seed);
        bus(1'b1, 0, pwk_pkg::IDX_MAC_ADDR_LO, mac[31:0]);
        bus(1'b1, 0, pwk_pkg::IDX_MAC_ADDR_HI, {16'h0, mac[47:32]});
        rd(0, pwk_pkg::IDX_MAC_ADDR_LO, mac[31:0]);
        rd(0, pwk_pkg::IDX_MAC_ADDR_HI, {16'h0, mac[47:32]});
        for (int p = 1; p <= 3; p++)
        begin
            pulse(p, 0, ~mac);
            rd(p, pwk_pkg::IDX_WAKE_EVENT, 32'h0);
            pulse(p, 0, mac);
            rd(p, pwk_pkg::IDX_WAKE_EVENT, 32'h4);
            outs(3'b000);
            bus(1'b1, p, pwk_pkg::IDX_WAKE_ENABLE, 32'h4);
            outs(3'b100);
            bus(1'b1, p, pwk_pkg::IDX_WAKE_EVENT, 32'h4);
            outs(3'b000);
        end
        for (int p = 1; p <= 3; p++)
        begin
            pulse(p, 1, mac);
            pulse(p, 2, mac);
            rd(p, pwk_pkg::IDX_WAKE_EVENT, (p < 3) ? 32'h3 : 32'h0);
            bus(1'b1, p, pwk_pkg::IDX_WAKE_ENABLE, 32'h7);
            rd(p, pwk_pkg::IDX_WAKE_ENABLE, (p < 3) ? 32'h7 : 32'h4);
            outs({p < 3, 2'b00});
            bus(1'b1, p, pwk_pkg::IDX_WAKE_EVENT, 32'h1);
            rd(p, pwk_pkg::IDX_WAKE_EVENT, (p < 3) ? 32'h2 : 32'h0);
            bus(1'b1, p, pwk_pkg::IDX_WAKE_EVENT, 32'h2);
            outs(3'b000);
        end
        for (int p = 1; p <= 3; p++)
        begin
            ev[p-1].ts_pending <= 1'b1;
            repeat (5) @(posedge clock_i);
            rd(p, pwk_pkg::IDX_INT_SUMMARY, (p < 3) ? 32'h4 : 32'h0);
            ev[p-1].phy_pending <= 1'b1;
            repeat (5) @(posedge clock_i);
            rd(p, pwk_pkg::IDX_INT_SUMMARY, (p < 3) ? 32'h6 : 32'h0);
            outs({1'b0, p < 3, 1'b0});
            bus(1'b1, p, pwk_pkg::IDX_INT_MASK, 32'h6);
            rd(p, pwk_pkg::IDX_INT_MASK, 32'h6);
            outs(3'b000);
            bus(1'b1, p, pwk_pkg::IDX_INT_MASK, 32'h0);
            bus(1'b1, p, pwk_pkg::IDX_INT_SUMMARY, 32'hff);
            rd(p, pwk_pkg::IDX_INT_SUMMARY, (p < 3) ? 32'h6 : 32'h0);
            ev[p-1].ts_pending <= 1'b0;
            ev[p-1].phy_pending <= 1'b0;
            repeat (5) @(posedge clock_i);
            rd(p, pwk_pkg::IDX_INT_SUMMARY, 32'h0);
            pulse(p, 3, mac);
            rd(p, pwk_pkg::IDX_INT_SUMMARY, 32'h1);
            outs(3'b010);
            bus(1'b1, p, pwk_pkg::IDX_INT_MASK, 32'h1);
            rd(p, pwk_pkg::IDX_INT_SUMMARY, 32'h0);
            pulse(p, 3, mac);
            outs(3'b000);
            rd(p, pwk_pkg::IDX_INT_SUMMARY, 32'h1);
            bus(1'b1, p, pwk_pkg::IDX_INT_MASK, 32'h0);
            rd(p, pwk_pkg::IDX_INT_SUMMARY, 32'h0);
        end
        rd(0, pwk_pkg::IDX_IRQ_STATUS, 32'h7);
        bus(1'b1, 0, pwk_pkg::IDX_IRQ_ENABLE, 32'h1);
        rd(0, pwk_pkg::IDX_IRQ_ENABLE, 32'h1);
        outs(3'b001);
        bus(1'b1, 0, pwk_pkg::IDX_IRQ_CLEAR, 32'h7);
        rd(0, pwk_pkg::IDX_IRQ_STATUS, 32'h0);
        rd(0, pwk_pkg::IDX_IRQ_CLEAR, 32'h0);
        outs(3'b000);
        check({24'h0, rises}, 32'h5);
        stop_test();
    end
endmodule
`default_nettype wire
